// *** dio_pkg.sv ***
// constants and types for the direct/immediate operand decoder
// assumes a 16-bit instruction stream and a classic Wishbone register port
package dio_pkg;
   localparam int          WORD_W        = 16;
   localparam int          PAGE_W        = 9;
   localparam int          OFFSET_W      = 7;
   localparam int          PAGE_WORDS    = 128;
   localparam int          PAGE_COUNT    = 512;
   // instruction word fields
   localparam int          MODE_BIT      = 7;
   localparam int          OPC_LSB       = 8;
   localparam int          OPC_W         = 8;
   localparam int          SHIFT_W       = 4;
   localparam logic        MODE_DIRECT   = 1'b0;
   // opcode patterns
   localparam logic [7:0]  REPEAT_OPC    = 8'hBB;   // 8-bit constant in bits 7:0
   localparam logic [6:0]  LOAD_PAGE_OPC = 7'h5E;   // 9-bit constant in bits 8:0
   localparam logic [2:0]  MPY_IMM_OPC   = 3'h6;    // 13-bit constant in bits 12:0
   localparam logic [11:0] ADD_LONG_OPC  = 12'hBF9; // shift in bits 3:0, constant follows
   localparam logic [7:0]  ADD_SH16_OPC  = 8'h61;   // add with shift of 16, direct operand
   localparam logic [7:0]  ADD_CARRY_OPC = 8'h60;   // add with carry, no shift
   // register map (byte offsets)
   localparam logic [7:0]  STATUS0_OFS   = 8'h00;
   localparam logic [7:0]  LASTADDR_OFS  = 8'h04;
   localparam logic [6:0]  STATUS0_HI_RST = 7'h00;
   typedef enum logic [2:0] {
      DIO_CLS_DIRECT,
      DIO_CLS_INDIRECT,
      DIO_CLS_SHORT8,
      DIO_CLS_SHORT9,
      DIO_CLS_SHORT13,
      DIO_CLS_LONG
   } dio_class_t;
   typedef enum logic {
      DIO_SEQ_OPCODE,
      DIO_SEQ_LONGWORD
   } dio_seq_t;
endpackage

// *** dio_direct_immediate_decode.sv ***
// direct and immediate operand decoder with data-page pointer
// fed by the fetch stage one word per insnValid pulse; addresses go to the data bus path
// Overview of operation
// - short constants of 8, 9, 13 bits
// - short-immediate takes one word, no fetch
// - long-immediate constant from second latched word
// - long constant passed through unchanged
// - data space is 512 pages of 128
// - page selected by 9-bit pointer field
// - bit 7 zero selects direct addressing
// - bit 7 one hands off to indirect
// - bits 15:8 give type and shift; shiftAmount is decoded for direct words except 0x6x and, from bits 3:0, for long opcodes, and reads zero for indirect words
// - bits 6:0 give offset in page
// - address is pointer above seven offset bits
// - reset leaves page pointer untouched
// - page load writes only the pointer field
// - shift-by-16 is its own opcode
// - no-shift ops use all eight bits
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module dio_direct_immediate_decode
   import dio_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic [WORD_W-1:0] insnWord,
   input  wire logic              insnValid,
   output logic      [WORD_W-1:0] operand,
   output logic                   operandValid,
   output logic                   operandLong,
   output logic                   secondWordPending,
   output logic      [WORD_W-1:0] dataAddr,
   output logic                   dataAddrValid,
   output logic                   indirectValid,
   output logic      [6:0]        indirectField,
   output logic      [OPC_W-1:0]  opcodeField,
   output logic      [SHIFT_W-1:0] shiftAmount,
   output logic                   shiftBy16,
   output logic                   noShiftOp,
   output logic                   pageLoad,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o
);

   // decode priority, highest first:
   //   long-immediate opcode (its constant follows in the next word)
   //   8-bit short constant
   //   9-bit short constant, which is also the page load
   //   13-bit short constant
   //   bit 7 set: indirect, handed to the auxiliary register path
   //   anything else: direct, offset in the low seven bits
   // the opcode patterns do not overlap one another, but all of them must be
   // tested before the bit 7 test, which any of their words could also pass

   function automatic dio_class_t classify(input logic [WORD_W-1:0] w);
      dio_class_t c;
      c = DIO_CLS_DIRECT;
      if (w[15:4] == ADD_LONG_OPC)
         c = DIO_CLS_LONG;
      else if (w[15:8] == REPEAT_OPC)
         c = DIO_CLS_SHORT8;
      else if (w[15:9] == LOAD_PAGE_OPC)
         c = DIO_CLS_SHORT9;
      else if (w[15:13] == MPY_IMM_OPC)
         c = DIO_CLS_SHORT13;
      else if (w[MODE_BIT] != MODE_DIRECT)
         c = DIO_CLS_INDIRECT;
      return c;
   endfunction

   logic [WORD_W-1:0]   instruction_word_latch;
   logic [PAGE_W-1:0]   data_page_pointer;
   logic [6:0]          statusHigh;
   dio_seq_t            seqState;
   dio_class_t          wordClass;
   logic                acceptOpcode;
   logic                acceptLong;
   logic                busWrite;
   logic                busRead;
   logic                statusSel;
   logic                loadPageInsn;
   logic [WORD_W-1:0]   status_word_zero;

   assign wordClass        = classify(insnWord);
   assign acceptOpcode     = insnValid && (seqState == DIO_SEQ_OPCODE);
   assign acceptLong       = insnValid && (seqState == DIO_SEQ_LONGWORD);
   assign loadPageInsn     = acceptOpcode && (wordClass == DIO_CLS_SHORT9);
   // a write lands at the edge where the master sees ack high, so a master
   // that gives up before ack never leaves a half-done write behind
   assign busWrite         = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   // read data is loaded one edge early so that it stands with ack
   assign busRead          = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign statusSel        = (wb_adr_i == STATUS0_OFS);
   assign status_word_zero = {statusHigh, data_page_pointer};

   // fetch sequencing: a long-immediate opcode claims the following word
   // the word after a long opcode is never decoded; a constant that happens
   // to look like an opcode must not start a new instruction
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         seqState <= DIO_SEQ_OPCODE;
      end else begin
         case (seqState)
            DIO_SEQ_OPCODE: begin
               if (acceptOpcode && wordClass == DIO_CLS_LONG)
                  seqState <= DIO_SEQ_LONGWORD;
            end
            DIO_SEQ_LONGWORD: begin
               if (acceptLong)
                  seqState <= DIO_SEQ_OPCODE;
            end
            default: seqState <= DIO_SEQ_OPCODE;
         endcase
      end
   end


   // copy of the last word taken, kept for whoever debugs the pipeline
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         instruction_word_latch <= '0;
      else if (insnValid)
         instruction_word_latch <= insnWord;
   end


   // level seen by the fetch stage: the next word is a constant, not an opcode
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         secondWordPending <= 1'b0;
      else if (acceptOpcode)
         secondWordPending <= (wordClass == DIO_CLS_LONG);
      else if (acceptLong)
         secondWordPending <= 1'b0;
   end


   // immediate operands
   // short constants are zero-extended; the long constant is passed on
   // untouched so that the consumer may read it signed or unsigned
   // operand holds its value between pulses; only operandValid marks news
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         operand      <= '0;
         operandValid <= 1'b0;
         operandLong  <= 1'b0;
      end else begin
         operandValid <= 1'b0;
         if (acceptLong) begin
            operand      <= insnWord;
            operandValid <= 1'b1;
            operandLong  <= 1'b1;
         end else if (acceptOpcode) begin
            operandLong <= 1'b0;
            case (wordClass)
               DIO_CLS_SHORT8: begin
                  operand      <= {8'h00, insnWord[7:0]};
                  operandValid <= 1'b1;
               end
               DIO_CLS_SHORT9: begin
                  operand      <= {7'h00, insnWord[8:0]};
                  operandValid <= 1'b1;
               end
               DIO_CLS_SHORT13: begin
                  operand      <= {3'h0, insnWord[12:0]};
                  operandValid <= 1'b1;
               end
               default: operandValid <= 1'b0;
            endcase
         end
      end
   end


   // opcode field and shift decoding
   // shift of 16 has no field of its own: it is carried by the whole top byte
   // the 0x6x opcodes carry no shift nibble, so their amount reads as zero
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         opcodeField <= '0;
         shiftAmount <= '0;
         shiftBy16   <= 1'b0;
         noShiftOp   <= 1'b0;
      end else if (acceptOpcode) begin
         opcodeField <= insnWord[OPC_LSB +: OPC_W];
         shiftBy16   <= (insnWord[15:8] == ADD_SH16_OPC);
         noShiftOp   <= (insnWord[15:8] == ADD_CARRY_OPC);
         if (wordClass == DIO_CLS_LONG)
            shiftAmount <= insnWord[3:0];
         else if (wordClass == DIO_CLS_DIRECT && insnWord[15:12] != 4'h6)
            shiftAmount <= insnWord[11:8];
         else
            shiftAmount <= '0;
      end
   end


   // direct address formation and indirect hand-off
   // 512 pages of 128 words: nine pointer bits above seven offset bits
   // cover the whole 64K data space with no gap and no overlap
   // the pointer in use is the one already latched; a page load in the
   // same cycle as a direct word cannot happen, both need an opcode slot
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dataAddr      <= '0;
         dataAddrValid <= 1'b0;
         indirectValid <= 1'b0;
         indirectField <= '0;
      end else begin
         dataAddrValid <= 1'b0;
         indirectValid <= 1'b0;
         if (acceptOpcode && wordClass == DIO_CLS_DIRECT) begin
            dataAddr      <= {data_page_pointer, insnWord[OFFSET_W-1:0]};
            dataAddrValid <= 1'b1;
         end
         if (acceptOpcode && wordClass == DIO_CLS_INDIRECT) begin
            indirectField <= insnWord[6:0];
            indirectValid <= 1'b1;
         end
      end
   end


   // page pointer has no reset and holds until rewritten
   // software must load it before the first direct access; until then the
   // upper nine address bits are unknown
   // the page load instruction wins over a bus write in the same cycle
   always_ff @(posedge mclk) begin
      if (loadPageInsn)
         data_page_pointer <= insnWord[PAGE_W-1:0];
      else if (busWrite && statusSel) begin
         if (wb_sel_i[0])
            data_page_pointer[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            data_page_pointer[8] <= wb_dat_i[8];
      end
   end


   // the rest of the status word resets; a page load never touches it
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         statusHigh <= STATUS0_HI_RST;
      else if (busWrite && statusSel && wb_sel_i[1])
         statusHigh <= wb_dat_i[15:9];
   end


   // one-cycle report that the pointer was written by either path
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         pageLoad <= 1'b0;
      else
         pageLoad <= loadPageInsn || (busWrite && statusSel && (wb_sel_i[1:0] != 2'b00));
   end


   // wishbone slave: ack one cycle after the strobe, dropped the cycle after
   // unmapped addresses are still acked so a stray access cannot hang the bus
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
   end


   // read data: loaded on the first strobe cycle, held until the next read
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wb_dat_o <= '0;
      end else if (busRead) begin
         case (wb_adr_i)
            STATUS0_OFS:  wb_dat_o <= {16'h0000, status_word_zero};
            LASTADDR_OFS: wb_dat_o <= {15'h0000, secondWordPending, dataAddr};
            default:      wb_dat_o <= '0;
         endcase
      end
   end

   // limitation: the page pointer reads back unknown after power-up
   // until software or a page load instruction has written it
endmodule
`default_nettype wire

// *** dio_sva.sv ***
// port checker for the direct/immediate operand decoder
// bound to every decoder instance; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dio_sva
   import dio_pkg::*;
(
   input wire logic              mclk,
   input wire logic              resetn,
   input wire logic [WORD_W-1:0] insnWord,
   input wire logic              insnValid,
   input wire logic [WORD_W-1:0] operand,
   input wire logic              operandValid,
   input wire logic              operandLong,
   input wire logic              secondWordPending,
   input wire logic [WORD_W-1:0] dataAddr,
   input wire logic              dataAddrValid,
   input wire logic              indirectValid,
   input wire logic [OPC_W-1:0]  opcodeField,
   input wire logic              shiftBy16,
   input wire logic              noShiftOp,
   input wire logic              pageLoad
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // a word that is not the constant half of a long pair
   wire logic newOp = insnValid && !secondWordPending;
   a_long_pend: assert property (newOp && insnWord[15:4] == ADD_LONG_OPC |=> secondWordPending && !operandValid)
      else $error("long opcode did not wait for its constant");
   a_long_const: assert property (secondWordPending && insnValid |=> operandValid && operandLong
      && operand == $past(insnWord)) else $error("long constant altered or missing");
   a_short_eight: assert property (newOp && insnWord[15:8] == REPEAT_OPC |=> operandValid && !secondWordPending
      && operand == {8'h00, $past(insnWord[7:0])}) else $error("short constant wrong");
   a_page_load: assert property (newOp && insnWord[15:9] == LOAD_PAGE_OPC |=> pageLoad
      && operand[8:0] == $past(insnWord[8:0])) else $error("page load not reported");
   a_direct_mode: assert property (dataAddrValid |-> !$past(insnWord[MODE_BIT])
      && dataAddr[6:0] == $past(insnWord[6:0])) else $error("direct offset wrong");
   a_indirect_mode: assert property (indirectValid |-> $past(insnWord[MODE_BIT]) && !dataAddrValid)
      else $error("indirect word misrouted");
   a_opcode_field: assert property (dataAddrValid |-> opcodeField == $past(insnWord[15:8]))
      else $error("opcode field wrong");
   a_shift_sixteen: assert property (dataAddrValid && opcodeField == ADD_SH16_OPC |-> shiftBy16 && !noShiftOp)
      else $error("shift of 16 not decoded");
endmodule
bind dio_direct_immediate_decode dio_sva u_sva (.mclk(mclk), .resetn(resetn), .insnWord(insnWord),
   .insnValid(insnValid), .operand(operand), .operandValid(operandValid), .operandLong(operandLong),
   .secondWordPending(secondWordPending), .dataAddr(dataAddr), .dataAddrValid(dataAddrValid),
   .indirectValid(indirectValid), .opcodeField(opcodeField), .shiftBy16(shiftBy16),
   .noShiftOp(noShiftOp), .pageLoad(pageLoad));
`default_nettype wire

// *** dio_fetch_model.sv ***
// fetch-stage model: hands one word a cycle to the decoder
// assumes the bench asks for a word with sendValid
`timescale 1ns/1ps
`default_nettype none
module dio_fetch_model
   import dio_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic [WORD_W-1:0] sendWord,
   input  wire logic              sendValid,
   output logic      [WORD_W-1:0] insnWord,
   output logic                   insnValid
);
   // idle word is the inverse of the last one, so a stale sample never matches
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         insnValid <= 1'b0;
         insnWord  <= 16'hA5A5;
      end else begin
         insnValid <= sendValid;
         insnWord  <= sendValid ? sendWord : ~insnWord;
      end
   end
endmodule
`default_nettype wire

// *** dio_direct_immediate_decode_bench.sv ***
// bench for the operand decoder: words via the fetch model, registers via Wishbone
// assumes dio_pkg, the decoder, the fetch model and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module dio_direct_immediate_decode_bench;
   import dio_pkg::*;
   logic        mclk, resetn, sendValid, insnValid, cyc, stb, we, ack, operandValid, operandLong;
   logic        pend, dataAddrValid, indirectValid, shiftBy16, noShiftOp, pageLoad;
   logic [15:0] sendWord, insnWord, operand, dataAddr;
   logic [7:0]  adr, opc;
   logic [3:0]  shamt;
   logic [6:0]  indField;
   logic [31:0] wdat, rdat, rd;
   int          error_cnt = 0;
   int          num_checks = 0;
   dio_fetch_model fetch (.mclk(mclk), .resetn(resetn), .sendWord(sendWord), .sendValid(sendValid),
      .insnWord(insnWord), .insnValid(insnValid));
   dio_direct_immediate_decode dut (.mclk(mclk), .resetn(resetn), .insnWord(insnWord), .insnValid(insnValid),
      .operand(operand), .operandValid(operandValid), .operandLong(operandLong), .secondWordPending(pend),
      .dataAddr(dataAddr), .dataAddrValid(dataAddrValid), .indirectValid(indirectValid), .indirectField(indField),
      .opcodeField(opc), .shiftAmount(shamt), .shiftBy16(shiftBy16), .noShiftOp(noShiftOp), .pageLoad(pageLoad),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask
   task automatic send(input logic [15:0] w);
      @(posedge mclk);
      sendWord  <= w;
      sendValid <= 1'b1;
   endtask
   // last word reaches the decoder one edge later, its result one edge after that
   task automatic flush;
      @(posedge mclk);
      sendValid <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat;
      {cyc, stb} <= 2'b00;
      if (ack !== 1'b1) begin
         error_cnt++;
         finish_test();
      end
      @(posedge mclk);
   endtask
   task automatic t_page_direct;
      send(16'hBC04);
      send(16'h2009);
      flush();
      chk("direct address", 32'h0209, dataAddr);
      send(16'h607F);
      flush();
      chk("same page", 32'h027F, dataAddr);
      chk("no shift", 1, noShiftOp);
      chk("add_with_carry_op opcode", 32'h60, opc);
      chk("add_with_carry_op shift", 0, shamt);
      chk("page geometry", 32'h10000, PAGE_WORDS * PAGE_COUNT);
   endtask
   task automatic t_short;
      send(16'hBB63);
      flush();
      chk("short 8", 32'h0063, operand);
      chk("short valid", 1, operandValid);
      chk("pending", 0, pend);
      send(16'hDFFF);
      flush();
      chk("short 13", 32'h1FFF, operand);
      send(16'hBDFF);
      send(16'h617F);
      flush();
      chk("top page", 32'hFFFF, dataAddr);
      chk("shift 16", 1, shiftBy16);
      chk("shift 16 field", 0, shamt);
      chk("shift 16 opcode", 32'h61, opc);
   endtask
   task automatic t_long;
      send(16'hBF92);
      flush();
      chk("pending", 1, pend);
      chk("long opcode", 32'hBF, opc);
      chk("long shift", 2, shamt);
      send(16'h4000);
      send(16'hBF90);
      send(16'h8000);
      flush();
      chk("long value", 32'h8000, operand);
      chk("long flag", 1, operandLong);
      send(16'h2089);
      flush();
      chk("indirect", 1, indirectValid);
      chk("indirect field", 32'h09, indField);
   endtask
   task automatic t_bus;
      wb(1'b1, STATUS0_OFS, 32'hFE05);
      wb(1'b0, STATUS0_OFS, 32'h0);
      chk("status", 32'hFE05, rd);
      send(16'hBC03);
      send(16'h2009);
      flush();
      wb(1'b0, STATUS0_OFS, 32'h0);
      chk("status", 32'hFE03, rd);
      wb(1'b0, LASTADDR_OFS, 32'h0);
      chk("last address", 32'h0189, rd);
      wb(1'b0, 8'h08, 32'h0);
      chk("unmapped", 32'h0, rd);
      @(posedge mclk);
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      send(16'h207F);
      flush();
      chk("page kept", 32'h01FF, dataAddr);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      resetn = 1'b0;
      sendValid = 1'b0;
      sendWord = 16'h0000;
      {cyc, stb, we, adr, wdat} = '0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      t_page_direct();
      t_short();
      t_long();
      t_bus();
      finish_test();
   end
endmodule
`default_nettype wire
